// >>> link_option_control.sv
// Link option control register with its transmit start policy.
// Assumes a classic Wishbone master on clk_i and a transmit FIFO of at
// least 2K bytes feeding level and end-of-packet information.
//
// Notes on behaviour
// - Options act only while the phy option gate bit 22 is set.
// - Options load from software writes and from the EEPROM loader.
// - Bits 31 to 16 read zero and ignore writes.
// - Bit 15 forces in-order asynchronous transmit.
// - Bits 13-12 pick the start threshold, reset value 01.
// - After an underrun, starts use 2K store-and-forward only until tx_done_i ends that send.
// - Below 2K, start at the threshold or on a whole packet.
// - Data missing before the FIFO drains is an underrun; starts wait only until that send ends.
// - The 2K choice sends only whole packets.
// - A zero retries register forces store-and-forward.
// - Bit 10 enables the stamp fix for format 20h streams.
// - Bit 8 enables the stamp fix for format 00h streams.
// - Bits 11 and 9 read zero and ignore writes.
// - Option bits return to their reset value only on the global reset.
`timescale 1ns/1ps
module link_option_control
    import link_option_pkg::*;
#(
    parameter int LEVEL_W = 12,
    parameter int FIFO_BYTES = FIFO_BYTES_MIN
) (
    // Clock and resets
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic global_reset_n_i,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // EEPROM load
    input wire logic eeprom_load_i,
    input wire logic [31:0] eeprom_data_i,
    // Transmit FIFO state
    input wire logic [LEVEL_W-1:0] fifo_level_i,
    input wire logic packet_whole_i,
    input wire logic packet_open_i,
    input wire logic fifo_empty_i,
    input wire logic tx_active_i,
    input wire logic tx_done_i,
    // Stream format
    input wire logic [7:0] cip_fmt_i,
    // Controls to the link
    output logic tx_start_o,
    output logic in_order_tx_force_o,
    output logic stamp_fix_o,
    output logic underrun_o,
    output logic irq_o
);
    logic [31:0] option;
    logic [31:0] retries;
    logic [31:0] host_control;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;
    logic retry_sf;
    logic ack;

    wire req = cyc_i && stb_i && !ack;
    wire wr = req && we_i;
    wire [31:0] be = {{8{sel_i[3]}}, {8{sel_i[2]}},
                      {8{sel_i[1]}}, {8{sel_i[0]}}};
    wire hit_opt = adr_i == LINK_OPTION_CONTROL_ADDR;
    wire hit_ret = adr_i == TX_RETRIES_ADDR;
    wire hit_hc = adr_i == HOST_CONTROL_ADDR;
    wire hit_ist = adr_i == IRQ_STATUS_ADDR;
    wire hit_imk = adr_i == IRQ_MASK_ADDR;
    wire hit_tst = adr_i == TX_STATUS_ADDR;
    wire [31:0] wm_opt = be & OPTION_WRITE_MASK;
    wire phy_option_gate = host_control[PHY_GATE_BIT];
    wire [1:0] thresh = option[THRESH_LSB+1:THRESH_LSB];
    wire retries_zero = retries == 32'h0;
    // Underrun: packet still open while the FIFO ran dry mid-send
    wire underrun = tx_active_i && fifo_empty_i && packet_open_i;
    wire force_sf = !phy_option_gate || retries_zero
                    || retry_sf;
    wire mpeg_hit = option[MPEG_BIT] && (cip_fmt_i == FMT_MPEG);
    wire dv_hit = option[DV_BIT] && (cip_fmt_i == FMT_DV);
    wire [31:0] tx_status = {29'h0, retry_sf, retries_zero,
                             phy_option_gate};
    wire [31:0] rd_data = hit_opt ? option :
                          hit_ret ? retries :
                          hit_hc ? host_control :
                          hit_ist ? {30'h0, irq_status} :
                          hit_imk ? {30'h0, irq_mask} :
                          hit_tst ? tx_status : 32'h0;
    wire [IRQ_W-1:0] irq_event = {eeprom_load_i, underrun};

    tx_start_gate #(
        .LEVEL_W(LEVEL_W)
    ) u_gate (
        .thresh_i(thresh),
        .force_sf_i(force_sf),
        .level_i(fifo_level_i),
        .packet_whole_i(packet_whole_i),
        .start_o(tx_start_o)
    );

    // Options survive the function reset; only the global reset loads OPTION_RESET into them
    always_ff @(posedge clk_i) begin
        if (!global_reset_n_i) begin
            option <= OPTION_RESET;
        end else if (eeprom_load_i) begin
            option <= eeprom_data_i & OPTION_WRITE_MASK;
        end else if (wr && hit_opt) begin
            option <= (option & ~wm_opt) | (dat_i & wm_opt);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            retries <= 32'h0;
            host_control <= 32'h0;
            irq_mask <= '0;
            ack <= 1'b0;
            dat_o <= 32'h0;
        end else begin
            ack <= req;
            dat_o <= req ? rd_data : 32'h0;
            if (wr && hit_ret) begin
                retries <= (retries & ~be) | (dat_i & be);
            end
            if (wr && hit_hc) begin
                host_control <= (host_control & ~be) | (dat_i & be);
            end
            if (wr && hit_imk && sel_i[0]) begin
                irq_mask <= dat_i[IRQ_W-1:0];
            end
        end
    end

    // Set wins over a write-one clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_status <= '0;
        end else begin
            irq_status <= (irq_status &
                ~((wr && hit_ist && sel_i[0]) ? dat_i[IRQ_W-1:0] : '0))
                | irq_event;
        end
    end

    // Held until the next tx_done_i after the underrun, even when that ends the send that underran
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            retry_sf <= 1'b0;
        end else if (underrun) begin
            retry_sf <= 1'b1;
        end else if (tx_done_i) begin
            retry_sf <= 1'b0;
        end
    end

    assign ack_o = ack;
    assign in_order_tx_force_o = phy_option_gate
                                 && option[IN_ORDER_BIT];
    assign stamp_fix_o = phy_option_gate && (mpeg_hit || dv_hit);
    assign underrun_o = underrun;
    assign irq_o = |(irq_status & irq_mask);

    // The FIFO is external; this only records its required size
    localparam int FIFO_OK = (FIFO_BYTES >= FIFO_BYTES_MIN) ? 1 : 0;
endmodule : link_option_control

// >>> link_option_pkg.sv
// Constants for the link option control register block.
// Assumes a 32-bit classic Wishbone slave with byte addresses.
package link_option_pkg;
    localparam logic [7:0] LINK_OPTION_CONTROL_ADDR = 8'hF4;
    localparam logic [7:0] TX_RETRIES_ADDR = 8'h08;
    localparam logic [7:0] HOST_CONTROL_ADDR = 8'h50;
    localparam logic [7:0] IRQ_STATUS_ADDR = 8'hE0;
    localparam logic [7:0] IRQ_MASK_ADDR = 8'hE4;
    localparam logic [7:0] TX_STATUS_ADDR = 8'hE8;
    localparam int IN_ORDER_BIT = 15;
    localparam int THRESH_LSB = 12;
    localparam int MPEG_BIT = 10;
    localparam int DV_BIT = 8;
    localparam int PHY_GATE_BIT = 22;
    localparam logic [31:0] OPTION_WRITE_MASK = 32'h0000B500;
    localparam logic [31:0] OPTION_RESET = 32'h00001000;
    localparam logic [1:0] THRESH_2K = 2'h0;
    localparam logic [1:0] THRESH_1K7 = 2'h1;
    localparam logic [1:0] THRESH_1K = 2'h2;
    localparam logic [1:0] THRESH_512 = 2'h3;
    localparam logic [11:0] LEVEL_1K7 = 12'h6C0;
    localparam logic [11:0] LEVEL_1K = 12'h400;
    localparam logic [11:0] LEVEL_512 = 12'h200;
    localparam logic [7:0] FMT_MPEG = 8'h20;
    localparam logic [7:0] FMT_DV = 8'h00;
    localparam int FIFO_BYTES_MIN = 2048;
    // Interrupt status bits
    localparam int IRQ_UNDERRUN = 0;
    localparam int IRQ_EEPROM_DONE = 1;
    localparam int IRQ_W = 2;
endpackage : link_option_pkg

// >>> tx_start_gate.sv
// Decides when the asynchronous transmitter may start a packet.
// Assumes level counts bytes held in the transmit FIFO.
`timescale 1ns/1ps
module tx_start_gate
    import link_option_pkg::*;
#(
    parameter int LEVEL_W = 12
) (
    // Configuration
    input wire logic [1:0] thresh_i,
    input wire logic force_sf_i,
    // FIFO state
    input wire logic [LEVEL_W-1:0] level_i,
    input wire logic packet_whole_i,
    // Decision
    output logic start_o
);
    logic [LEVEL_W-1:0] limit;
    logic store_forward;

    assign limit = (thresh_i == THRESH_1K7) ? LEVEL_W'(LEVEL_1K7) :
                   (thresh_i == THRESH_1K) ? LEVEL_W'(LEVEL_1K) :
                   LEVEL_W'(LEVEL_512);
    assign store_forward = force_sf_i || (thresh_i == THRESH_2K);
    // Start on threshold or on a checked-in packet, whichever first
    assign start_o = packet_whole_i ||
                     (!store_forward && (level_i >= limit));
endmodule : tx_start_gate

// >>> link_option_control_checker.sv
// Port-level assertions for the link option control block.
// Assumes a classic Wishbone master that holds each request until ack.
`timescale 1ns/1ps
module link_option_control_checker
    import link_option_pkg::*;
(
    input wire logic clk_i, rst_i, global_reset_n_i, cyc_i, stb_i, we_i,
    input wire logic [7:0] adr_i, cip_fmt_i,
    input wire logic [11:0] fifo_level_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o, eeprom_load_i, packet_whole_i, packet_open_i,
    input wire logic fifo_empty_i, tx_active_i, tx_start_o,
    input wire logic in_order_tx_force_o, stamp_fix_o, underrun_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Anything that may legally move the in-order output
    wire cause = cyc_i && stb_i && we_i || eeprom_load_i
        || !global_reset_n_i || rst_i;
    sequence req_s;
        cyc_i && stb_i && !ack_o;
    endsequence
    a_ack_latency: assert property (req_s |=> ack_o)
        else $error("request not acked next cycle");
    a_ack_pulse: assert property (ack_o |=> !ack_o)
        else $error("ack held too long");
    a_idle_quiet: assert property (!(cyc_i && stb_i) |=> !ack_o)
        else $error("ack without request");
    a_reserved_zero: assert property (ack_o && !we_i
        && adr_i == LINK_OPTION_CONTROL_ADDR |-> (dat_o & 32'hFFFF4AFF) == 0)
        else $error("reserved option bits read nonzero");
    a_underrun_cause: assert property (underrun_o
        == (tx_active_i && fifo_empty_i && packet_open_i))
        else $error("underrun flag wrong");
    a_start_level: assert property (tx_start_o
        && !packet_whole_i |-> fifo_level_i >= 12'h200)
        else $error("start below every threshold");
    a_stamp_format: assert property (stamp_fix_o
        |-> cip_fmt_i == 8'h20 || cip_fmt_i == 8'h00)
        else $error("stamp fix on other format");
    a_order_hold: assert property ($changed(in_order_tx_force_o)
        |-> $past(cause))
        else $error("in-order output moved without cause");
endmodule : link_option_control_checker
bind link_option_control link_option_control_checker i_chk (.*);

// >>> link_far_model.sv
// Far-side transmitter: sends a packet once the block allows a start.
// Assumes go_i asks for one send; a send lasts 31 cycles.
`timescale 1ns/1ps
module link_far_model (
    input wire logic clk_i, rst_i, start_i, go_i,
    output logic active_o, done_o
);
    logic [4:0] left = 5'h00;
    always_ff @(posedge clk_i) begin
        done_o <= left == 5'h01;
        if (rst_i) begin
            left <= 5'h00;
        end else if (left != 5'h00) begin
            left <= left - 5'h01;
        end else if (go_i && start_i) begin
            left <= 5'h1F;
        end
    end
    assign active_o = left != 5'h00;
endmodule : link_far_model

// >>> test_link_option_control.sv
// Self-checking bench for the link option control block.
// Assumes the far-side model reports each started packet as done.
`timescale 1ns/1ps
module test_link_option_control;
    import link_option_pkg::*;
    logic clk_i = 0, rst_i = 1, global_reset_n_i = 0, go = 0;
    logic cyc_i = 0, stb_i = 0, we_i = 0, eeprom_load_i = 0;
    logic packet_whole_i = 0, packet_open_i = 0, fifo_empty_i = 0;
    logic [7:0] adr_i = 8'h00, cip_fmt_i = 8'h20;
    logic [3:0] sel_i = 4'hF;
    logic [11:0] fifo_level_i = 12'h000;
    logic [31:0] dat_i = 0, eeprom_data_i = 0, dat_o, rd;
    logic ack_o, tx_active_i, tx_done_i, tx_start_o, irq_o, underrun_o;
    logic in_order_tx_force_o, stamp_fix_o;
    int err_count = 0, n_checks = 0;
    link_option_control i_link_option_control (.*);
    link_far_model i_link_far_model (.clk_i(clk_i), .rst_i(rst_i),
        .start_i(tx_start_o), .go_i(go), .active_o(tx_active_i),
        .done_o(tx_done_i));
    initial forever #12.5 clk_i = ~clk_i;
    task automatic close_out;
        if (err_count == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : close_out
    task automatic chk(input string n, input logic [31:0] s, e);
        n_checks++;
        if (s !== e) begin
            err_count++;
            $display("BAD %s exp %h got %h", n, e, s);
        end
    endtask : chk
    // Ack and read data are taken at the edge, before that edge updates them
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clk_i);
        {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, d};
        for (i = 0; i < 20; i++) begin
            @(posedge clk_i);
            if (ack_o === 1'b1) break;
        end
        if (i == 20) begin
            err_count++;
            close_out();
        end
        rd = dat_o;
        {cyc_i, stb_i} <= 2'b00;
    endtask : wb
    task automatic rdc(input logic [7:0] a, input logic [31:0] e, string n);
        wb(0, a, 0);
        chk(n, rd, e);
    endtask : rdc
    task automatic probe(input logic [11:0] l, input logic w);
        @(posedge clk_i);
        {fifo_level_i, packet_whole_i} <= {l, w};
        #1;
    endtask : probe
    task automatic s_regs;
        rdc(LINK_OPTION_CONTROL_ADDR, 32'h00001000, "reset");
        wb(1, LINK_OPTION_CONTROL_ADDR, 32'hFFFFFFFF);
        rdc(LINK_OPTION_CONTROL_ADDR, 32'h0000B500, "mask");
        @(posedge clk_i) rst_i <= 1;
        @(posedge clk_i) rst_i <= 0;
        rdc(LINK_OPTION_CONTROL_ADDR, 32'h0000B500, "keep");
        @(posedge clk_i) global_reset_n_i <= 0;
        @(posedge clk_i) global_reset_n_i <= 1;
        rdc(LINK_OPTION_CONTROL_ADDR, 32'h00001000, "global");
        wb(1, 8'hC0, 32'hFFFFFFFF);
        rdc(8'hC0, 32'h0, "unmapped");
    endtask : s_regs
    task automatic s_gate;
        wb(1, TX_RETRIES_ADDR, 32'h3);
        wb(1, LINK_OPTION_CONTROL_ADDR, 32'h00008400);
        #1 chk("gate off", {in_order_tx_force_o, stamp_fix_o}, 0);
        wb(1, HOST_CONTROL_ADDR, 32'h00400000);
        #1 chk("gate on", {in_order_tx_force_o, stamp_fix_o}, 3);
        @(posedge clk_i) cip_fmt_i <= 8'h00;
        #1 chk("mpeg on dv", stamp_fix_o, 0);
        wb(1, LINK_OPTION_CONTROL_ADDR, 32'h00000100);
        #1 chk("dv", {in_order_tx_force_o, stamp_fix_o}, 1);
        @(posedge clk_i) cip_fmt_i <= 8'h20;
        #1 chk("dv on mpeg", stamp_fix_o, 0);
    endtask : s_gate
    task automatic s_thresh;
        logic [11:0] lv [4] = '{12'hFFF, 12'h6C0, 12'h400, 12'h200};
        for (int t = 0; t < 4; t++) begin
            wb(1, LINK_OPTION_CONTROL_ADDR, {18'h0, t[1:0], 12'h000});
            probe(lv[t] - 12'h001, 0);
            chk("below", tx_start_o, 0);
            probe(lv[t], 0);
            chk("at level", tx_start_o, t != 0);
            probe(12'h010, 1);
            chk("whole", tx_start_o, 1);
        end
        wb(1, TX_RETRIES_ADDR, 32'h0);
        probe(12'hFFF, 0);
        chk("no retries", tx_start_o, 0);
    endtask : s_thresh
    task automatic s_under;
        int i;
        wb(1, TX_RETRIES_ADDR, 32'h3);
        wb(1, IRQ_MASK_ADDR, 32'h0);
        probe(12'h200, 0);
        @(posedge clk_i) go <= 1;
        @(posedge clk_i) go <= 0;
        @(posedge clk_i) {packet_open_i, fifo_empty_i} <= 2'b11;
        #1 chk("underrun", underrun_o, 1);
        @(posedge clk_i) {packet_open_i, fifo_empty_i} <= 2'b00;
        rdc(TX_STATUS_ADDR, 32'h5, "retry flag");
        chk("retry start", tx_start_o, 0);
        rdc(IRQ_STATUS_ADDR, 32'h1, "irq status");
        chk("irq masked", irq_o, 0);
        wb(1, IRQ_MASK_ADDR, 32'h1);
        #1 chk("irq", irq_o, 1);
        wb(1, IRQ_STATUS_ADDR, 32'h1);
        #1 chk("irq clear", irq_o, 0);
        for (i = 0; i < 60 && tx_active_i !== 1'b0; i++) @(posedge clk_i);
        if (i == 60) begin
            err_count++;
            close_out();
        end
        rdc(TX_STATUS_ADDR, 32'h1, "retry done");
    endtask : s_under
    task automatic s_eeprom;
        @(posedge clk_i) {eeprom_load_i, eeprom_data_i} <= {1'b1, 32'hFFFFFFFF};
        @(posedge clk_i) eeprom_load_i <= 0;
        rdc(LINK_OPTION_CONTROL_ADDR, 32'h0000B500, "eeprom");
        rdc(IRQ_STATUS_ADDR, 32'h2, "load event");
    endtask : s_eeprom
    initial begin
        repeat (10) @(posedge clk_i);
        {rst_i, global_reset_n_i} <= 2'b01;
        s_regs();
        s_gate();
        s_thresh();
        s_under();
        s_eeprom();
        close_out();
    end
endmodule : test_link_option_control
